// ---- dv/ctrl_props.sv ----
// assertion checker for the tdm control registers
`timescale 1ns/1ps
`default_nettype none
module ctrl_props(input wire logic clock_in, rst_in, wr_in, block_program_enable_in, frame_start_in,
    master_mode_in, slave_pll_enable_in, prog_busy_out, prog_fill_out, switch_soft_reset_out,
    pll_soft_reset_out, clock_output_five_oe_out, clock_output_four_oe_out, delayed_frame_pulse2_oe_out,
    delayed_frame_pulse1_oe_out, delayed_frame_pulse0_oe_out, input wire logic [13:0] addr_in,
    input wire logic [15:0] wdata_in, input wire logic [2:0] block_pattern_field_out,
    input wire logic [3:0] clock_pulse_pair_oe_out);
wire w1 = wr_in && addr_in == 14'h1;
wire w2 = wr_in && addr_in == 14'h2;
wire w3 = wr_in && addr_in == 14'h3;
default clocking @(posedge clock_in); endclocking
default disable iff (rst_in);
property p_st; w1 && wdata_in[0] && !prog_busy_out |=> prog_busy_out; endproperty
a_st: assert property (p_st) else $error("no launch");
property p_dn; prog_fill_out && frame_start_in && block_program_enable_in |=> !prog_busy_out; endproperty
a_dn: assert property (p_dn) else $error("no finish");
property p_ab; prog_busy_out && $past(block_program_enable_in) && !block_program_enable_in |=> !prog_busy_out;
endproperty
a_ab: assert property (p_ab) else $error("no abort");
property p_sr; w2 |=> {switch_soft_reset_out, pll_soft_reset_out} == $past(wdata_in[1:0]); endproperty
a_sr: assert property (p_sr) else $error("reset bits");
property p_pr; w3 |=> clock_pulse_pair_oe_out == $past(wdata_in[3:0]); endproperty
a_pr: assert property (p_pr) else $error("pair enables");
property p_dl; w3 |=> {delayed_frame_pulse2_oe_out, delayed_frame_pulse1_oe_out, delayed_frame_pulse0_oe_out} ==
    $past(wdata_in[8:6]); endproperty
a_dl: assert property (p_dl) else $error("delayed pulse enables");
property p_ck; w3 && wdata_in[5:4] == 2'h0 |=> !clock_output_five_oe_out && !clock_output_four_oe_out; endproperty
a_ck: assert property (p_ck) else $error("clock enables");
property p_md; clock_output_five_oe_out || clock_output_four_oe_out |-> $past(master_mode_in, 2) ||
    $past(slave_pll_enable_in, 2); endproperty
a_md: assert property (p_md) else $error("mode gate");
property p_kp; prog_busy_out && !block_program_enable_in && !wr_in |=> $stable(block_pattern_field_out); endproperty
a_kp: assert property (p_kp) else $error("pattern moved");
cover property (prog_fill_out && frame_start_in);
cover property (prog_busy_out && $past(block_program_enable_in) && !block_program_enable_in);
cover property (w1 && !wdata_in[0] && prog_busy_out);
cover property (clock_output_five_oe_out && clock_output_four_oe_out);
endmodule // ctrl_props
bind tdm_switch_mode_reset_output_ctrl ctrl_props i_ctrl_props(.*);
`default_nettype wire

// ---- dv/host_model.sv ----
// host bus model for the tdm control registers
`timescale 1ns/1ps
`default_nettype none
module host_model(input wire logic clock_in, output logic [13:0] addr_in = 14'h0, output logic [15:0] wdata_in = 16'h0,
    output logic wr_in = 1'b0, output logic rd_in = 1'b0, input wire logic [15:0] rdata_out);
task acc(input logic w, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock_in) #1;
    {addr_in, wdata_in, wr_in, rd_in} = {a, d, w, !w};
    @(posedge clock_in) #1;
    {wr_in, rd_in} = 2'h0;
    q = rdata_out;
endtask
endmodule // host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// top testbench for the tdm control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic clock_in = 0, rst_in = 1, en = 0, frm = 0, mst = 0, slv = 0;
logic [15:0] q, d;
logic [13:0] a;
logic [31:0] x = 32'h4bf2;
int failures = 0, checks = 0;
wire [13:0] addr_in;
wire [15:0] wdata_in, rdata_out;
wire wr_in, rd_in, busy, ck5, ck4, fill;
tdm_switch_mode_reset_output_ctrl i_tdm_switch_mode_reset_output_ctrl(.clock_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .block_program_enable_in(en), .frame_start_in(frm), .master_mode_in(mst),
    .slave_pll_enable_in(slv), .prog_busy_out(busy), .prog_fill_out(fill), .block_pattern_field_out(),
    .switch_soft_reset_out(), .pll_soft_reset_out(), .delayed_frame_pulse2_oe_out(), .delayed_frame_pulse1_oe_out(),
    .delayed_frame_pulse0_oe_out(), .clock_output_five_oe_out(ck5), .clock_output_four_oe_out(ck4),
    .clock_pulse_pair_oe_out());
host_model i_host_model(.clock_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out);
initial forever #10 clock_in = ~clock_in;
function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
endfunction
task chk(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
        failures++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask
task frame;
    @(posedge clock_in) #1 frm = 1;
    @(posedge clock_in) #1 frm = 0;
endtask
task wrap_up;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clock_in);
    #1 rst_in = 0;
    for (int i = 0; i < 30; i++) begin
        a = 14'(rnd() % 5);
        d = rnd();
        if (a == 14'h1) d[0] = 0;
        i_host_model.acc(1, a, d, q);
        i_host_model.acc(0, a, 16'h0, q);
        chk(q, a == 14'h1 ? d & 16'h017e : a == 14'h2 ? d & 16'h0003 : a == 14'h3 ? d & 16'h01ff : 16'h0);
    end
    i_host_model.acc(1, 14'h3, 16'h0030, q);
    repeat (4) @(posedge clock_in);
    #1 chk({14'h0, ck5, ck4}, 16'h0);
    slv = 1;
    repeat (4) @(posedge clock_in);
    #1 chk({14'h0, ck5, ck4}, 16'h3);
    i_host_model.acc(1, 14'h1, 16'h0001, q);
    chk({15'h0, busy}, 16'h1);
    @(posedge clock_in) #1 en = 1;
    @(posedge clock_in) #1 en = 0;
    @(posedge clock_in) #1 chk({15'h0, busy}, 16'h0);
    en = 1;
    i_host_model.acc(1, 14'h1, 16'h0005, q);
    chk({15'h0, busy}, 16'h1);
    frame;
    chk({15'h0, busy}, 16'h1);
    chk({15'h0, fill}, 16'h1);
    frame;
    i_host_model.acc(0, 14'h1, 16'h0, q);
    chk(q, 16'h0004);
    i_host_model.acc(1, 14'h1, 16'h0003, q);
    i_host_model.acc(1, 14'h1, 16'h0002, q);
    i_host_model.acc(0, 14'h1, 16'h0, q);
    chk(q, 16'h0002);
    wrap_up;
end
initial begin
    #20000;
    failures++;
    wrap_up;
end
endmodule // tb_top
`default_nettype wire

// ---- inc/tdm_ctrl_regs.vh ----
// register offsets, field positions and reset values of the mode, reset and output enable registers
`ifndef TDM_CTRL_REGS_VH
`define TDM_CTRL_REGS_VH
`define ADDR_MODE 14'h0001
`define ADDR_SWRST 14'h0002
`define ADDR_OUTEN 14'h0003
`define MODE_START_BIT 0
`define MODE_PATTERN_LSB 1
`define MODE_PATTERN_MSB 3
`define MODE_MISC_LSB 4
`define MODE_WMASK 16'h017f
`define SWRST_SWITCH_BIT 1
`define SWRST_PLL_BIT 0
`define SWRST_WMASK 16'h0003
`define OUTEN_WMASK 16'h01ff
`define OUTEN_DLY2_BIT 8
`define OUTEN_DLY1_BIT 7
`define OUTEN_DLY0_BIT 6
`define OUTEN_CK5_BIT 5
`define OUTEN_CK4_BIT 4
`define OUTEN_PAIR_MSB 3
`define OUTEN_PAIR_LSB 0
`define MODE_RESET 16'h0000
`define SWRST_RESET 16'h0000
`define OUTEN_RESET 16'h0000
`define PROG_FRAMES 2'h2
`endif

// ---- rtl/tdm_switch_mode_reset_output_ctrl.v ----
// mode, software reset and output enable registers of the tdm switch control port
`timescale 1ns/1ps
`default_nettype none
`include "tdm_ctrl_regs.vh"
module tdm_switch_mode_reset_output_ctrl (
    input wire clock_in,
    input wire rst_in,
    input wire [13:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire block_program_enable_in,
    input wire frame_start_in,
    input wire master_mode_in,
    input wire slave_pll_enable_in,
    output wire prog_busy_out,
    output reg prog_fill_out,
    output wire [2:0] block_pattern_field_out,
    output wire switch_soft_reset_out,
    output wire pll_soft_reset_out,
    output wire delayed_frame_pulse2_oe_out,
    output wire delayed_frame_pulse1_oe_out,
    output wire delayed_frame_pulse0_oe_out,
    output wire clock_output_five_oe_out,
    output wire clock_output_four_oe_out,
    output wire [3:0] clock_pulse_pair_oe_out
);

////////////////////////////////////////////////////////////////////////////////
// reset words of the three registers
localparam [15:0] MODE_RESET_WORD = `MODE_RESET;
localparam [15:0] SWRST_RESET_WORD = `SWRST_RESET;
localparam [15:0] OUTEN_RESET_WORD = `OUTEN_RESET;

////////////////////////////////////////////////////////////////////////////////
// address and data helpers
function addr_hit;
    input [13:0] addr;
    input [13:0] target;
    begin
        addr_hit = (addr == target);
    end
endfunction

function [15:0] masked_word;
    input [15:0] data;
    input [15:0] mask;
    begin
        masked_word = data & mask;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// two-flop synchronisers for the mode strap pins
reg master_s1_r;
reg master_s2_r;
reg slave_s1_r;
reg slave_s2_r;

always @(posedge clock_in) begin
    if (rst_in) begin
        master_s1_r <= 1'b0;
        master_s2_r <= 1'b0;
    end else begin
        master_s1_r <= master_mode_in;
        master_s2_r <= master_s1_r;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        slave_s1_r <= 1'b0;
        slave_s2_r <= 1'b0;
    end else begin
        slave_s1_r <= slave_pll_enable_in;
        slave_s2_r <= slave_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register state
reg start_r;
reg [2:0] pattern_r;
reg [15:4] mode_misc_r;
reg switch_reset_r;
reg pll_reset_r;
reg [2:0] delayed_en_r;
reg [1:0] clock45_en_r;
reg [3:0] pair_en_r;
reg [1:0] frame_cnt_r;
reg [1:0] frame_cnt_nxt;
reg start_nxt;
reg fill_nxt;
reg enable_d_r;
reg [15:0] read_value;
wire [15:0] mode_masked;
wire [15:0] swrst_masked;
wire [15:0] outen_masked;
wire [15:0] mode_word;
wire [15:0] swrst_word;
wire [15:0] outen_word;
wire mode_wr;
wire swrst_wr;
wire outen_wr;
wire start_rise;
wire start_drop;
wire enable_fall;
wire frame_tick;
wire last_frame;
wire ck45_avail;

////////////////////////////////////////////////////////////////////////////////
// write decode
assign mode_wr = wr_in && addr_hit(addr_in, `ADDR_MODE);
assign swrst_wr = wr_in && addr_hit(addr_in, `ADDR_SWRST);
assign outen_wr = wr_in && addr_hit(addr_in, `ADDR_OUTEN);
assign mode_masked = masked_word(wdata_in, `MODE_WMASK);
assign swrst_masked = masked_word(wdata_in, `SWRST_WMASK);
assign outen_masked = masked_word(wdata_in, `OUTEN_WMASK);

////////////////////////////////////////////////////////////////////////////////
// programming events
assign start_rise = mode_wr && wdata_in[`MODE_START_BIT] && !start_r;
assign start_drop = mode_wr && !wdata_in[`MODE_START_BIT];
assign enable_fall = enable_d_r && !block_program_enable_in;
assign frame_tick = frame_start_in && block_program_enable_in;
assign last_frame = (frame_cnt_r == (`PROG_FRAMES - 2'h1));

// enable history for the falling-edge abort
always @(posedge clock_in) begin
    if (rst_in) begin
        enable_d_r <= 1'b0;
    end else begin
        enable_d_r <= block_program_enable_in;
    end
end

////////////////////////////////////////////////////////////////////////////////
// programming sequencer
always @* begin
    start_nxt = start_r;
    fill_nxt = prog_fill_out;
    frame_cnt_nxt = frame_cnt_r;
    if (start_rise) begin
        start_nxt = 1'b1;
        fill_nxt = 1'b0;
        frame_cnt_nxt = 2'h0;
    end else if (start_r) begin
        if (start_drop || enable_fall) begin
            start_nxt = 1'b0;
            fill_nxt = 1'b0;
            frame_cnt_nxt = 2'h0;
        end else if (frame_tick) begin
            if (last_frame) begin
                start_nxt = 1'b0;
                fill_nxt = 1'b0;
                frame_cnt_nxt = 2'h0;
            end else begin
                fill_nxt = 1'b1;
                frame_cnt_nxt = frame_cnt_r + 2'h1;
            end
        end
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        frame_cnt_r <= 2'h0;
    end else begin
        frame_cnt_r <= frame_cnt_nxt;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        prog_fill_out <= 1'b0;
    end else begin
        prog_fill_out <= fill_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode register
always @(posedge clock_in) begin
    if (rst_in) begin
        start_r <= MODE_RESET_WORD[`MODE_START_BIT];
    end else begin
        start_r <= start_nxt;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        pattern_r <= MODE_RESET_WORD[`MODE_PATTERN_MSB:`MODE_PATTERN_LSB];
        mode_misc_r <= MODE_RESET_WORD[15:`MODE_MISC_LSB];
    end else if (mode_wr) begin
        pattern_r <= mode_masked[`MODE_PATTERN_MSB:`MODE_PATTERN_LSB];
        mode_misc_r <= mode_masked[15:`MODE_MISC_LSB];
    end
end

assign mode_word = {mode_misc_r, pattern_r, start_r};

////////////////////////////////////////////////////////////////////////////////
// software reset register
always @(posedge clock_in) begin
    if (rst_in) begin
        switch_reset_r <= SWRST_RESET_WORD[`SWRST_SWITCH_BIT];
    end else if (swrst_wr) begin
        switch_reset_r <= swrst_masked[`SWRST_SWITCH_BIT];
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        pll_reset_r <= SWRST_RESET_WORD[`SWRST_PLL_BIT];
    end else if (swrst_wr) begin
        pll_reset_r <= swrst_masked[`SWRST_PLL_BIT];
    end
end

assign swrst_word = {14'h0000, switch_reset_r, pll_reset_r};

////////////////////////////////////////////////////////////////////////////////
// output enable register
always @(posedge clock_in) begin
    if (rst_in) begin
        delayed_en_r <= OUTEN_RESET_WORD[`OUTEN_DLY2_BIT:`OUTEN_DLY0_BIT];
    end else if (outen_wr) begin
        delayed_en_r <= outen_masked[`OUTEN_DLY2_BIT:`OUTEN_DLY0_BIT];
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        clock45_en_r <= OUTEN_RESET_WORD[`OUTEN_CK5_BIT:`OUTEN_CK4_BIT];
    end else if (outen_wr) begin
        clock45_en_r <= outen_masked[`OUTEN_CK5_BIT:`OUTEN_CK4_BIT];
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        pair_en_r <= OUTEN_RESET_WORD[`OUTEN_PAIR_MSB:`OUTEN_PAIR_LSB];
    end else if (outen_wr) begin
        pair_en_r <= outen_masked[`OUTEN_PAIR_MSB:`OUTEN_PAIR_LSB];
    end
end

assign outen_word = {7'h00, delayed_en_r, clock45_en_r, pair_en_r};

////////////////////////////////////////////////////////////////////////////////
// read data
always @* begin
    read_value = 16'h0000;
    if (addr_hit(addr_in, `ADDR_MODE)) begin
        read_value = mode_word;
    end else if (addr_hit(addr_in, `ADDR_SWRST)) begin
        read_value = swrst_word;
    end else if (addr_hit(addr_in, `ADDR_OUTEN)) begin
        read_value = outen_word;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        rdata_out <= 16'h0000;
    end else if (rd_in) begin
        rdata_out <= read_value;
    end
end

////////////////////////////////////////////////////////////////////////////////
// programming status outputs
assign prog_busy_out = start_r;
assign block_pattern_field_out = pattern_r;

////////////////////////////////////////////////////////////////////////////////
// software reset outputs
assign switch_soft_reset_out = switch_reset_r;
assign pll_soft_reset_out = pll_reset_r;

////////////////////////////////////////////////////////////////////////////////
// output enables
assign ck45_avail = master_s2_r || slave_s2_r;
assign delayed_frame_pulse2_oe_out = delayed_en_r[2];
assign delayed_frame_pulse1_oe_out = delayed_en_r[1];
assign delayed_frame_pulse0_oe_out = delayed_en_r[0];
assign clock_output_five_oe_out = clock45_en_r[1] && ck45_avail;
assign clock_output_four_oe_out = clock45_en_r[0] && ck45_avail;
assign clock_pulse_pair_oe_out = pair_en_r;

endmodule // tdm_switch_mode_reset_output_ctrl
`default_nettype wire
